// [subclass_decoder.sv]
// Purpose: Classifies 16-bit halfwords of six encoding classes, registered
// Assumes: Halfword and valid strobe are synchronous to core_clk
// Notes: One cycle latency; outputs come straight from flip-flops
//
// What this block does
// RULE_01: Class 010000 opcodes 0000-0100 give and, xor, shifts on registers.
// RULE_02: Opcodes 0101-0111 give add with carry, subtract with carry, rotate.
// RULE_03: Opcodes 1000-1011 give flag test, negate, compare, compare negated.
// RULE_04: Opcodes 1100-1111 give or, multiply, bit clear, invert.
// RULE_05: Class 010001: 00xx add, 0100 unpredictable, 0101/011x compare, 10xx move.
// RULE_06: Special class 110x branch-exchange, 111x branch-link-exchange.
// RULE_07: Top field 0101, 011x, 100x is load/store, qualified by next field.
// RULE_08: Register offset form: eight loads and stores by the three-bit field.
// RULE_09: Immediate forms: 0110 word, 0111 byte, 1000 half; MSB picks load.
// RULE_10: Top field 1001 is stack-relative word store or load.
// RULE_11: Misc 00000xx adds immediate to stack, 00001xx subtracts.
// RULE_12: Misc extend and byte-reverse opcodes as allocated.
// RULE_13: Misc push, pop, state change, breakpoint and hint subspace.
// RULE_14: Unallocated miscellaneous opcodes are flagged undefined.
// RULE_15: Hint with nonzero low field is undefined.
// RULE_16: Hint upper field 0000-0100 gives nop, yield, wait, wait irq, send.
// RULE_17: Other hints with zero low field execute as no-operation.
// RULE_18: Class 1101: branch unless 111x; 1110 undefined; 1111 supervisor call.
// RULE_19: Bits 15:11 of 11101, 11110, 11111 mark a wide instruction.
// RULE_20: Undefined encodings raise an undefined-instruction indication.
// RULE_21: Field positions follow the fixed bit layout of each class.
module subclass_decoder
   import halfword_decode_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [halfword_decode_pkg::HW_W-1:0] hw,
   input wire logic hw_valid,
   output logic dec_valid,
   output halfword_decode_pkg::op_e op,
   output logic undef,
   output logic unpred,
   output logic wide,
   output logic hit
);
   import halfword_decode_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Class decoders
   state_s state_q;
   state_s state_d;
   dec_s ls_dec;
   dec_s misc_dec;
   logic [3:0] opc4;
   logic [3:0] br_opc;

   assign opc4 = hw[9:6]; // see RULE_21
   assign br_opc = hw[11:8]; // see RULE_21

   load_store_decode u_ls (
      .hw(hw),
      .dec(ls_dec)
   );

   misc_class_decode u_misc (
      .hw(hw),
      .dec(misc_dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      state_d = state_q;
      state_d.valid = hw_valid;
      state_d.dec = '0;
      state_d.dec.op = none_op;
      if (hw[15:14] == WIDE_TOP && hw[13:11] >= WIDE_LOW_MIN)
      begin
         state_d.dec.wide = 1'b1; // see RULE_19
      end
      else if (hw[15:10] == DP_TOP)
      begin
         state_d.dec.hit = 1'b1;
         case (opc4)
            4'h0: state_d.dec.op = and_op; // see RULE_01
            4'h1: state_d.dec.op = exclusive_or_op; // see RULE_01
            4'h2: state_d.dec.op = left_shift_op; // see RULE_01
            4'h3: state_d.dec.op = logical_right_shift_op; // see RULE_01
            4'h4: state_d.dec.op = arith_right_shift_op; // see RULE_01
            4'h5: state_d.dec.op = add_carry_op; // see RULE_02
            4'h6: state_d.dec.op = subtract_carry_op; // see RULE_02
            4'h7: state_d.dec.op = rotate_right_op; // see RULE_02
            4'h8: state_d.dec.op = flag_test_op; // see RULE_03
            4'h9: state_d.dec.op = reverse_subtract_op; // see RULE_03
            4'ha: state_d.dec.op = compare_op; // see RULE_03
            4'hb: state_d.dec.op = compare_negated_op; // see RULE_03
            4'hc: state_d.dec.op = inclusive_or_op; // see RULE_04
            4'hd: state_d.dec.op = multiply_op; // see RULE_04
            4'he: state_d.dec.op = bit_clear_op; // see RULE_04
            default: state_d.dec.op = invert_op; // see RULE_04
         endcase
      end
      else if (hw[15:10] == SPECIAL_TOP)
      begin
         state_d.dec.hit = 1'b1;
         casez (opc4)
            4'b00??: state_d.dec.op = add_reg_op; // see RULE_05
            SPECIAL_UNPRED: state_d.dec.unpred = 1'b1; // see RULE_05
            4'b0101: state_d.dec.op = compare_op; // see RULE_05
            4'b011?: state_d.dec.op = compare_op; // see RULE_05
            4'b10??: state_d.dec.op = move_reg_op; // see RULE_05
            4'b110?: state_d.dec.op = branch_exchange_op; // see RULE_06
            default: state_d.dec.op = branch_link_exchange_op; // see RULE_06
         endcase
      end
      else if (hw[15:12] == MISC_TOP)
      begin
         state_d.dec = misc_dec; // see RULE_14
      end
      else if (hw[15:12] == BRANCH_TOP)
      begin
         state_d.dec.hit = 1'b1;
         case (br_opc) // see RULE_18
            BR_UNDEF:
            begin
               state_d.dec.op = permanent_undefined_op;
               state_d.dec.undef = 1'b1; // see RULE_20
            end
            BR_SVC: state_d.dec.op = supervisor_call_op;
            default: state_d.dec.op = cond_branch_op;
         endcase
      end
      else if (ls_dec.hit)
      begin
         state_d.dec = ls_dec; // see RULE_07
      end
      if (!hw_valid)
      begin
         state_d.dec = '0;
         state_d.dec.op = none_op;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign dec_valid = state_q.valid;
   assign op = state_q.dec.op;
   assign undef = state_q.dec.undef;
   assign unpred = state_q.dec.unpred;
   assign wide = state_q.dec.wide;
   assign hit = state_q.dec.hit;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   dp_xor_a: assert property ( // see RULE_01
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h101
      |=> op == exclusive_or_op)
      else $error("xor not decoded");

   dp_adc_a: assert property ( // see RULE_02
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h105
      |=> op == add_carry_op)
      else $error("add with carry not decoded");

   dp_cmn_a: assert property ( // see RULE_03
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h10b
      |=> op == compare_negated_op)
      else $error("compare negated not decoded");

   dp_mul_a: assert property ( // see RULE_04
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h10d
      |=> op == multiply_op)
      else $error("multiply not decoded");

   sp_unpred_a: assert property ( // see RULE_05
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h114
      |=> unpred && !undef)
      else $error("special unpredictable missed");

   bx_dec_a: assert property ( // see RULE_06
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:7] == 9'h8e
      |=> op == branch_exchange_op)
      else $error("branch exchange missed");

   ls_hit_a: assert property ( // see RULE_07
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && (hw[15:12] == 4'h5 || hw[15:13] == 3'h3
         || hw[15:13] == 3'h4)
      |=> hit && !undef && op != none_op)
      else $error("load store class missed");

   ls_sp_a: assert property ( // see RULE_10
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:11] == 5'h13
      |=> op == load_sp_word_op)
      else $error("stack load missed");

   ls_reg_a: assert property ( // see RULE_08
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:9] == 7'h2f
      |=> op == load_signed_half_op)
      else $error("signed half load missed");

   ls_imm_a: assert property ( // see RULE_09
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:11] == 5'h0e
      |=> op == store_byte_op)
      else $error("byte store missed");

   misc_add_a: assert property ( // see RULE_11
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:7] == 9'h160
      |=> op == sp_add_imm_op)
      else $error("stack add missed");

   misc_sp_a: assert property ( // see RULE_11
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:7] == 9'h161
      |=> op == sp_sub_imm_op)
      else $error("stack subtract missed");

   misc_rev_a: assert property ( // see RULE_12
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h2e8
      |=> op == byte_swap_word_op)
      else $error("byte reverse missed");

   misc_ext_a: assert property ( // see RULE_12
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:6] == 10'h2c9
      |=> op == sign_extend_byte_op)
      else $error("sign extend byte missed");

   misc_cps_a: assert property ( // see RULE_13
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:5] == 11'h5b3
      |=> op == state_change_op)
      else $error("state change missed");

   misc_push_a: assert property ( // see RULE_13
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:9] == 7'h5a
      |=> op == push_multi_op)
      else $error("push missed");

   misc_pop_a: assert property ( // see RULE_13
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:9] == 7'h5e
      |=> op == pop_multi_op)
      else $error("pop missed");

   misc_breakpoint_op_a: assert property ( // see RULE_13
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:8] == 8'hbe
      |=> op == breakpoint_op)
      else $error("breakpoint missed");

   misc_undef_a: assert property ( // see RULE_14
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:9] == 7'h5b && hw[8:5] != 4'h3
      |=> undef)
      else $error("unallocated misc not undefined");

   hint_undef_a: assert property ( // see RULE_15
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:8] == HINT_TOP && hw[3:0] != 4'h0
      |=> undef)
      else $error("hint with low field not undefined");

   hint_wfi_a: assert property ( // see RULE_16
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw == 16'hbf30
      |=> op == wait_interrupt_hint)
      else $error("wait interrupt missed");

   hint_sev_a: assert property ( // see RULE_16
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw == 16'hbf40
      |=> op == send_event_hint)
      else $error("send event missed");

   hint_nop_a: assert property ( // see RULE_17
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw == 16'hbf90
      |=> op == no_operation_hint && !undef)
      else $error("unallocated hint not nop");

   br_udf_a: assert property ( // see RULE_18
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:8] == 8'hde
      |=> undef && op == permanent_undefined_op)
      else $error("permanent undefined missed");

   br_svc_a: assert property ( // see RULE_18
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:8] == 8'hdf
      |=> op == supervisor_call_op && !undef)
      else $error("supervisor call missed");

   wide_a: assert property ( // see RULE_19
      @(posedge core_clk) disable iff (!rst_n)
      hw_valid && hw[15:11] >= 5'h1d
      |=> wide && !hit)
      else $error("wide halfword decoded");

   undef_src_a: assert property ( // see RULE_20
      @(posedge core_clk) disable iff (!rst_n)
      undef |-> $past(hw_valid) && ($past(hw[15:12]) == 4'hb
         || $past(hw[15:8]) == 8'hde))
      else $error("spurious undefined");

   idle_a: assert property ( // see RULE_21
      @(posedge core_clk) disable iff (!rst_n)
      !hw_valid
      |=> !dec_valid && !undef && !hit)
      else $error("decode without valid");

   hint_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      dec_valid && op == send_event_hint);
   undef_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      dec_valid && undef);
   load_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      dec_valid && op == load_signed_byte_op);
   branch_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      dec_valid && op == cond_branch_op ##1 dec_valid && wide);
   store_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      dec_valid && op == store_sp_word_op);

endmodule : subclass_decoder

// [halfword_decode_pkg.sv]
// Purpose: Shared types and field positions for the halfword class decoder
// Assumes: 16-bit halfwords arrive from fetch with a valid strobe
// Notes: Field positions and class codes are named once here
package halfword_decode_pkg;

   localparam int HW_W = 16;
   // Class selectors
   localparam logic [5:0] DP_TOP = 6'h10;
   localparam logic [5:0] SPECIAL_TOP = 6'h11;
   localparam logic [3:0] MISC_TOP = 4'hb;
   localparam logic [3:0] BRANCH_TOP = 4'hd;
   localparam logic [7:0] HINT_TOP = 8'hbf;
   localparam logic [1:0] WIDE_TOP = 2'h3;
   localparam logic [2:0] WIDE_LOW_MIN = 3'h5;
   // Load/store top fields
   localparam logic [3:0] LS_REG = 4'h5;
   localparam logic [3:0] LS_WORD_IMM = 4'h6;
   localparam logic [3:0] LS_BYTE_IMM = 4'h7;
   localparam logic [3:0] LS_HALF_IMM = 4'h8;
   localparam logic [3:0] LS_SP_REL = 4'h9;
   // Special data codes
   localparam logic [3:0] SPECIAL_UNPRED = 4'h4;
   // Miscellaneous exact codes
   localparam logic [6:0] MISC_STATE_CHANGE = 7'h33;
   // Branch codes
   localparam logic [3:0] BR_UNDEF = 4'he;
   localparam logic [3:0] BR_SVC = 4'hf;

   typedef enum logic [5:0] {
      none_op = 6'h00,
      and_op = 6'h01,
      exclusive_or_op = 6'h02,
      left_shift_op = 6'h03,
      logical_right_shift_op = 6'h04,
      arith_right_shift_op = 6'h05,
      add_carry_op = 6'h06,
      subtract_carry_op = 6'h07,
      rotate_right_op = 6'h08,
      flag_test_op = 6'h09,
      reverse_subtract_op = 6'h0a,
      compare_op = 6'h0b,
      compare_negated_op = 6'h0c,
      inclusive_or_op = 6'h0d,
      multiply_op = 6'h0e,
      bit_clear_op = 6'h0f,
      invert_op = 6'h10,
      add_reg_op = 6'h11,
      move_reg_op = 6'h12,
      branch_exchange_op = 6'h13,
      branch_link_exchange_op = 6'h14,
      store_word_op = 6'h15,
      store_half_op = 6'h16,
      store_byte_op = 6'h17,
      load_word_op = 6'h18,
      load_half_op = 6'h19,
      load_byte_op = 6'h1a,
      load_signed_byte_op = 6'h1b,
      load_signed_half_op = 6'h1c,
      store_sp_word_op = 6'h1d,
      load_sp_word_op = 6'h1e,
      sp_add_imm_op = 6'h1f,
      sp_sub_imm_op = 6'h20,
      sign_extend_half_op = 6'h21,
      sign_extend_byte_op = 6'h22,
      zero_extend_half_op = 6'h23,
      zero_extend_byte_op = 6'h24,
      push_multi_op = 6'h25,
      pop_multi_op = 6'h26,
      state_change_op = 6'h27,
      byte_swap_word_op = 6'h28,
      byte_swap_halves_op = 6'h29,
      byte_swap_signed_low_op = 6'h2a,
      breakpoint_op = 6'h2b,
      no_operation_hint = 6'h2c,
      yield_hint = 6'h2d,
      wait_event_hint = 6'h2e,
      wait_interrupt_hint = 6'h2f,
      send_event_hint = 6'h30,
      cond_branch_op = 6'h31,
      permanent_undefined_op = 6'h32,
      supervisor_call_op = 6'h33
   } op_e;

   typedef struct packed {
      op_e op;
      logic undef;
      logic unpred;
      logic wide;
      logic hit;
   } dec_s;

   typedef struct packed {
      logic valid;
      dec_s dec;
   } state_s;

endpackage : halfword_decode_pkg

// [misc_class_decode.sv]
// Purpose: Decodes the miscellaneous class including the hint subspace
// Assumes: Caller qualifies the class by the top four bits
// Notes: Purely combinational
module misc_class_decode
   import halfword_decode_pkg::*;
(
   input wire logic [HW_W-1:0] hw,
   output halfword_decode_pkg::dec_s dec
);
   logic [6:0] opc;
   logic [3:0] upper_subfield;
   logic [3:0] lower_subfield;
   assign opc = hw[11:5];
   assign upper_subfield = hw[7:4];
   assign lower_subfield = hw[3:0];

   always_comb
   begin
      dec = '0;
      dec.hit = 1'b1;
      dec.op = none_op;
      casez (opc)
         7'b00000??: dec.op = sp_add_imm_op; // see RULE_11
         7'b00001??: dec.op = sp_sub_imm_op; // see RULE_11
         7'b001000?: dec.op = sign_extend_half_op; // see RULE_12
         7'b001001?: dec.op = sign_extend_byte_op; // see RULE_12
         7'b001010?: dec.op = zero_extend_half_op; // see RULE_12
         7'b001011?: dec.op = zero_extend_byte_op; // see RULE_12
         7'b010????: dec.op = push_multi_op; // see RULE_13
         MISC_STATE_CHANGE: dec.op = state_change_op; // see RULE_13
         7'b101000?: dec.op = byte_swap_word_op; // see RULE_12
         7'b101001?: dec.op = byte_swap_halves_op; // see RULE_12
         7'b101011?: dec.op = byte_swap_signed_low_op; // see RULE_12
         7'b110????: dec.op = pop_multi_op; // see RULE_13
         7'b1110???: dec.op = breakpoint_op; // see RULE_13
         7'b1111???:
         begin
            if (lower_subfield != 4'h0)
               dec.undef = 1'b1; // see RULE_15
            else
               case (upper_subfield) // see RULE_16
                  4'h0: dec.op = no_operation_hint;
                  4'h1: dec.op = yield_hint;
                  4'h2: dec.op = wait_event_hint;
                  4'h3: dec.op = wait_interrupt_hint;
                  4'h4: dec.op = send_event_hint;
                  default: dec.op = no_operation_hint; // see RULE_17
               endcase
         end
         default: dec.undef = 1'b1; // see RULE_14
      endcase
   end
endmodule : misc_class_decode

// [load_store_decode.sv]
// Purpose: Decodes the single-item load/store class
// Assumes: Caller qualifies hit with the other classes
// Notes: Purely combinational
module load_store_decode
   import halfword_decode_pkg::*;
(
   input wire logic [HW_W-1:0] hw,
   output halfword_decode_pkg::dec_s dec
);
   logic [3:0] upper_subfield;
   logic [2:0] lower_subfield;
   assign upper_subfield = hw[15:12];
   assign lower_subfield = hw[11:9];

   always_comb
   begin
      dec = '0;
      dec.op = none_op;
      dec.hit = 1'b1; // see RULE_07
      case (upper_subfield)
         LS_REG:
            case (lower_subfield) // see RULE_08
               3'h0: dec.op = store_word_op;
               3'h1: dec.op = store_half_op;
               3'h2: dec.op = store_byte_op;
               3'h3: dec.op = load_signed_byte_op;
               3'h4: dec.op = load_word_op;
               3'h5: dec.op = load_half_op;
               3'h6: dec.op = load_byte_op;
               default: dec.op = load_signed_half_op;
            endcase
         LS_WORD_IMM: // see RULE_09
            dec.op = lower_subfield[2] ? load_word_op : store_word_op;
         LS_BYTE_IMM: // see RULE_09
            dec.op = lower_subfield[2] ? load_byte_op : store_byte_op;
         LS_HALF_IMM: // see RULE_09
            dec.op = lower_subfield[2] ? load_half_op : store_half_op;
         LS_SP_REL: // see RULE_10
            dec.op = lower_subfield[2] ? load_sp_word_op : store_sp_word_op;
         default: dec.hit = 1'b0;
      endcase
   end
endmodule : load_store_decode

// [fetch_model.sv]
// Purpose: Fetch stage model that presents halfwords to the decoder
// Assumes: Halfwords change just after a rising core_clk edge
// Notes: Released halfword bus shows the inverse of its last value
module fetch_model
   import halfword_decode_pkg::*;
(
   input wire logic core_clk,
   output logic [halfword_decode_pkg::HW_W-1:0] hw,
   output logic hw_valid
);
   import halfword_decode_pkg::*;

   initial
   begin
      hw = '0;
      hw_valid = 1'b0;
   end

   // Presents one halfword from the next edge on
   task automatic send(input logic [HW_W-1:0] word);
      @(posedge core_clk);
      hw <= word;
      hw_valid <= 1'b1;
   endtask : send

   // Drops the strobe and scrambles the stale halfword
   task automatic idle();
      @(posedge core_clk);
      hw <= ~hw;
      hw_valid <= 1'b0;
   endtask : idle
endmodule : fetch_model

// [subclass_decoder_tb.sv]
// Purpose: Self-checking bench for the halfword class decoder
// Assumes: One cycle latency, outputs zero in reset and without strobe
// Notes: Expected decodes come from tables kept in this bench
module subclass_decoder_tb
   import halfword_decode_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [HW_W-1:0] hw;
   logic hw_valid;
   logic dec_valid;
   op_e op;
   logic undef;
   logic unpred;
   logic wide;
   logic hit;
   int mismatches = 0;
   int n_tests = 0;
   logic [HW_W-1:0] last_hw = '0;
   op_e dp_tab [16] = '{and_op, exclusive_or_op, left_shift_op,
      logical_right_shift_op, arith_right_shift_op, add_carry_op,
      subtract_carry_op, rotate_right_op, flag_test_op, reverse_subtract_op,
      compare_op, compare_negated_op, inclusive_or_op, multiply_op,
      bit_clear_op, invert_op};
   op_e ls_tab [8] = '{store_word_op, store_half_op, store_byte_op,
      load_signed_byte_op, load_word_op, load_half_op, load_byte_op,
      load_signed_half_op};
   op_e st_tab [4] = '{store_word_op, store_byte_op, store_half_op,
      store_sp_word_op};
   op_e ld_tab [4] = '{load_word_op, load_byte_op, load_half_op,
      load_sp_word_op};
   logic [6:0] m_opc [25] = '{7'h00, 7'h03, 7'h04, 7'h07, 7'h10, 7'h13,
      7'h14, 7'h17, 7'h20, 7'h2f, 7'h33, 7'h50, 7'h53, 7'h57, 7'h60, 7'h6f,
      7'h70, 7'h77, 7'h08, 7'h18, 7'h30, 7'h32, 7'h38, 7'h40, 7'h5e};
   op_e m_op [25] = '{sp_add_imm_op, sp_add_imm_op, sp_sub_imm_op,
      sp_sub_imm_op, sign_extend_half_op, sign_extend_byte_op,
      zero_extend_half_op, zero_extend_byte_op, push_multi_op, push_multi_op,
      state_change_op, byte_swap_word_op, byte_swap_halves_op,
      byte_swap_signed_low_op, pop_multi_op, pop_multi_op, breakpoint_op,
      breakpoint_op, none_op, none_op, none_op, none_op, none_op, none_op,
      none_op};
   op_e h_tab [5] = '{no_operation_hint, yield_hint, wait_event_hint,
      wait_interrupt_hint, send_event_hint};
   logic [HW_W-1:0] x_hw [11] = '{16'he800, 16'hefff, 16'hf000, 16'hf800,
      16'hffff, 16'he000, 16'h0000, 16'h4800, 16'ha000, 16'ha800, 16'hc800};

   always #25 core_clk = ~core_clk;

   fetch_model fetch (.core_clk(core_clk), .hw(hw), .hw_valid(hw_valid));

   subclass_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .hw(hw),
      .hw_valid(hw_valid), .dec_valid(dec_valid), .op(op), .undef(undef),
      .unpred(unpred), .wide(wide), .hit(hit));

   ////////////////////////////////////////////////////////////////////////
   // Compare and drive helpers
   task automatic cmp(input logic ev, input op_e eo, input logic eu,
      input logic ep, input logic ew, input logic eh);
      n_tests++;
      if (dec_valid !== ev || op !== eo || undef !== eu || unpred !== ep ||
         wide !== ew || hit !== eh)
      begin
         mismatches++;
         $display("MISMATCH %0t: word %h gave op %s", $time, last_hw,
            op.name());
      end
   endtask : cmp

   task automatic chk(input logic [HW_W-1:0] word, input op_e eo,
      input logic eu, input logic ep, input logic ew, input logic eh);
      last_hw = word;
      fetch.send(word);
      @(posedge core_clk);
      #1;
      cmp(1'b1, eo, eu, ep, ew, eh);
   endtask : chk

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic dp_ops();
      for (int o = 0; o < 16; o++)
      begin
         chk({6'h10, 4'(o), 6'h2a}, dp_tab[o], 0, 0, 0, 1);
      end
   endtask : dp_ops

   task automatic special_ops();
      op_e e;
      for (int o = 0; o < 16; o++)
      begin
         e = o < 4 ? add_reg_op : o == 4 ? none_op : o < 8 ? compare_op :
            o < 12 ? move_reg_op : o < 14 ? branch_exchange_op :
            branch_link_exchange_op;
         chk({6'h11, 4'(o), 6'h15}, e, 0, o == 4, 0, 1);
      end
   endtask : special_ops

   task automatic load_store_ops();
      for (int b = 0; b < 8; b++)
      begin
         chk({4'h5, 3'(b), 9'h0a5}, ls_tab[b], 0, 0, 0, 1);
      end
      for (int t = 0; t < 4; t++)
      begin
         for (int b = 0; b < 8; b += 3)
         begin
            chk({4'(t + 6), 3'(b), 9'h15a}, b < 4 ? st_tab[t] : ld_tab[t],
               0, 0, 0, 1);
         end
      end
   endtask : load_store_ops

   task automatic misc_ops();
      for (int i = 0; i < 25; i++)
      begin
         chk({4'hb, m_opc[i], 5'h0b}, m_op[i], m_op[i] == none_op, 0, 0,
            1);
      end
   endtask : misc_ops

   task automatic hint_ops();
      for (int u = 0; u < 16; u++)
      begin
         chk({8'hbf, 4'(u), 4'h0}, u < 5 ? h_tab[u] : no_operation_hint,
            0, 0, 0, 1);
      end
      chk(16'hbf01, none_op, 1, 0, 0, 1);
      chk(16'hbf38, none_op, 1, 0, 0, 1);
      chk(16'hbf0f, none_op, 1, 0, 0, 1);
   endtask : hint_ops

   task automatic branch_ops();
      for (int o = 0; o < 16; o++)
      begin
         chk({4'hd, 4'(o), 8'h5a}, o < 14 ? cond_branch_op : o == 14 ?
            permanent_undefined_op : supervisor_call_op, o == 14, 0, 0,
            1);
      end
   endtask : branch_ops

   task automatic outside_ops();
      for (int i = 0; i < 11; i++)
      begin
         chk(x_hw[i], none_op, 0, 0, i < 5, 0);
      end
   endtask : outside_ops

   task automatic stream_ops();
      last_hw = 16'hbf30;
      fetch.send(16'hbf30);
      fetch.send(16'hde00);
      #1;
      cmp(1, wait_interrupt_hint, 0, 0, 0, 1);
      last_hw = 16'hde00;
      fetch.idle();
      #1;
      cmp(1, permanent_undefined_op, 1, 0, 0, 1);
      @(posedge core_clk);
      #1;
      cmp(0, none_op, 0, 0, 0, 0);
   endtask : stream_ops

   task automatic reset_mid_run();
      fetch.send(16'hde00);
      @(posedge core_clk);
      rst_n <= 1'b0;
      #1;
      cmp(0, none_op, 0, 0, 0, 0);
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      chk(16'h4340, multiply_op, 0, 0, 0, 1);
   endtask : reset_mid_run

   ////////////////////////////////////////////////////////////////////////
   // Run control
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      fetch.send(16'hde00);
      repeat (5) @(posedge core_clk);
      #1;
      cmp(0, none_op, 0, 0, 0, 0);
      repeat (14) @(posedge core_clk);
      rst_n <= 1'b1;
      dp_ops();
      special_ops();
      load_store_ops();
      misc_ops();
      hint_ops();
      branch_ops();
      outside_ops();
      stream_ops();
      reset_mid_run();
      finish_test();
   end
endmodule : subclass_decoder_tb
